// ---- common/fspa_map.svh ----
// Address map, field positions and timing counts of the self-program block
`ifndef FSPA_MAP_SVH
`define FSPA_MAP_SVH

// ********************************************************************
// Control register
// ********************************************************************
`define FSPA_CTRL_IO_ADDR     6'h37
`define FSPA_CTRL_DATA_ADDR   8'h57
`define FSPA_CTRL_RESET       8'h00
`define FSPA_BIT_IRQ_EN       7
`define FSPA_BIT_BUSY         6
`define FSPA_BIT_REENABLE     4
`define FSPA_BIT_LOCK         3
`define FSPA_BIT_PAGE_WRITE   2
`define FSPA_BIT_PAGE_ERASE   1
`define FSPA_BIT_ENABLE       0

// ********************************************************************
// Boot section table, one entry per boot-size select value
// ********************************************************************
`define FSPA_BOOT_START_11    13'h1F80
`define FSPA_APP_END_11       13'h1F7F
`define FSPA_BOOT_WORDS_11    11'h080
`define FSPA_BOOT_PAGES_11    5'h02
`define FSPA_BOOT_START_10    13'h1F00
`define FSPA_APP_END_10       13'h1EFF
`define FSPA_BOOT_WORDS_10    11'h100
`define FSPA_BOOT_PAGES_10    5'h04
`define FSPA_BOOT_START_01    13'h1E00
`define FSPA_APP_END_01       13'h1DFF
`define FSPA_BOOT_WORDS_01    11'h200
`define FSPA_BOOT_PAGES_01    5'h08
`define FSPA_BOOT_START_00    13'h1C00
`define FSPA_APP_END_00       13'h1BFF
`define FSPA_BOOT_WORDS_00    11'h400
`define FSPA_BOOT_PAGES_00    5'h10

// ********************************************************************
// Read-while-write partition
// ********************************************************************
`define FSPA_RWW_LAST         13'h1BFF
`define FSPA_RWW_PAGES        7'h70
`define FSPA_BLOCKING_REWRITE_REGION_FIRST       13'h1C00
`define FSPA_BLOCKING_REWRITE_REGION_LAST        13'h1FFF
`define FSPA_BLOCKING_REWRITE_REGION_PAGES       5'h10

// ********************************************************************
// Pointer fields and timing
// ********************************************************************
`define FSPA_PAGE_WORDS       7'h40
`define FSPA_Z_PAGE_HI        13
`define FSPA_Z_PAGE_LO        7
`define FSPA_Z_WORD_HI        6
`define FSPA_Z_WORD_LO        1
`define FSPA_Z_BYTE_BIT       0
`define FSPA_SPM_WINDOW_CYC   3'h4
`define FSPA_CFG_SETTLE_CYC   2'h3

`endif

// ---- common/fspa_pkg.sv ----
// Types and decode functions of the self-program block
package fspa_pkg;
`include "fspa_map.svh"

  typedef logic [12:0] fspa_waddr_t;

  typedef struct packed {
    logic [12:0] boot_start;
    logic [12:0] app_end;
    logic [10:0] boot_words;
    logic [4:0]  boot_pages;
  } fspa_sect_t;

  typedef struct packed {
    logic       erase;
    logic       write;
    logic       lock;
    logic [6:0] page;
    logic [7:0] lock_data;
  } fspa_flash_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [12:0] addr;
    logic [15:0] data;
  } fspa_flash_wr_t;

  typedef enum logic [1:0] {
    FSPA_IDLE   = 2'b00,
    FSPA_STREAM = 2'b01,
    FSPA_PROG   = 2'b11
  } fspa_state_t;

  function automatic fspa_sect_t fspa_decode_boot(input logic [1:0] sel);
    fspa_sect_t s;
    case (sel)
      2'b11:   s = '{`FSPA_BOOT_START_11, `FSPA_APP_END_11,
                     `FSPA_BOOT_WORDS_11, `FSPA_BOOT_PAGES_11};
      2'b10:   s = '{`FSPA_BOOT_START_10, `FSPA_APP_END_10,
                     `FSPA_BOOT_WORDS_10, `FSPA_BOOT_PAGES_10};
      2'b01:   s = '{`FSPA_BOOT_START_01, `FSPA_APP_END_01,
                     `FSPA_BOOT_WORDS_01, `FSPA_BOOT_PAGES_01};
      default: s = '{`FSPA_BOOT_START_00, `FSPA_APP_END_00,
                     `FSPA_BOOT_WORDS_00, `FSPA_BOOT_PAGES_00};
    endcase
    return s;
  endfunction : fspa_decode_boot

  function automatic logic fspa_in_rww(input logic [12:0] addr);
    return addr <= `FSPA_RWW_LAST;
  endfunction : fspa_in_rww

endpackage : fspa_pkg

// ---- hdl/fspa_boot_cfg.sv ----
// Boot-size strap capture and section decode
`timescale 1ns/10ps
`include "fspa_map.svh"
module fspa_boot_cfg
  import fspa_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic boot_size_sel_hi,
  input  wire logic boot_size_sel_lo,
  output fspa_sect_t sect_info,
  output logic       cfg_valid
);

  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  logic [1:0] sel_cap;
  logic [1:0] settle;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_meta <= 2'h0;
      sel_sync <= 2'h0;
    end
    else
    begin
      sel_meta <= {boot_size_sel_hi, boot_size_sel_lo};
      sel_sync <= sel_meta;
    end
  end

  // Captured once after reset; later strap changes are ignored
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      settle    <= 2'h0;
      cfg_valid <= 1'b0;
      sel_cap   <= 2'h0;
      sect_info <= '0;
    end
    else if (!cfg_valid)
    begin
      settle <= settle + 2'h1;
      if (settle == `FSPA_CFG_SETTLE_CYC)
      begin
        cfg_valid <= 1'b1;
        sel_cap   <= sel_sync;
        sect_info <= fspa_decode_boot(sel_sync);
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  chk_boot_size_11: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cfg_valid && sel_cap == 2'b11 |-> sect_info.boot_start == 13'h1F80 &&
    sect_info.app_end == 13'h1F7F && sect_info.boot_words == 11'h080)
    else $error("boot size 11 decode wrong");
  chk_boot_size_10: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cfg_valid && sel_cap == 2'b10 |-> sect_info.boot_start == 13'h1F00 &&
    sect_info.app_end == 13'h1EFF && sect_info.boot_pages == 5'h04)
    else $error("boot size 10 decode wrong");
  chk_boot_size_01: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cfg_valid && sel_cap == 2'b01 |-> sect_info.boot_start == 13'h1E00 &&
    sect_info.app_end == 13'h1DFF && sect_info.boot_pages == 5'h08)
    else $error("boot size 01 decode wrong");
  chk_boot_size_00: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cfg_valid && sel_cap == 2'b00 |-> sect_info.boot_start == 13'h1C00 &&
    sect_info.app_end == 13'h1BFF && sect_info.boot_words == 11'h400)
    else $error("boot size 00 decode wrong");
  chk_cfg_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cfg_valid |=> cfg_valid && $stable(sect_info))
    else $error("boot configuration changed while running");

endmodule : fspa_boot_cfg

// ---- hdl/fspa_flash_self_program_addressing.sv ----
// Self-programming address split, control register and page sequencer
`timescale 1ns/10ps
`include "fspa_map.svh"
module fspa_flash_self_program_addressing
  import fspa_pkg::*;
#(
  parameter int unsigned PROG_CYC = 16
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       boot_size_sel_hi,
  input  wire logic       boot_size_sel_lo,
  input  wire logic [5:0] io_addr,
  input  wire logic       io_wr_en,
  input  wire logic       io_rd_en,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  input  wire logic       spm_req,
  input  wire logic [15:0] spm_data,
  input  wire logic       lpm_req,
  input  wire logic [15:0] z_ptr,
  output logic            lpm_valid,
  output logic      [12:0] lpm_addr,
  output logic            lpm_byte_hi,
  output logic            lpm_blocked,
  output fspa_flash_cmd_t flash_cmd,
  output fspa_flash_wr_t  flash_wr,
  output fspa_sect_t      sect_info,
  output logic            cfg_valid,
  output logic            core_stall,
  output logic            spm_ready_irq
);

  // ********************************************************************
  // Pointer split
  // ********************************************************************
  logic [6:0]  z_page;
  logic [5:0]  z_word;
  logic [12:0] z_waddr;

  assign z_page  = z_ptr[`FSPA_Z_PAGE_HI:`FSPA_Z_PAGE_LO];
  assign z_word  = z_ptr[`FSPA_Z_WORD_HI:`FSPA_Z_WORD_LO];
  assign z_waddr = z_ptr[`FSPA_Z_PAGE_HI:`FSPA_Z_WORD_LO];

  // ********************************************************************
  // Control register and command window
  // ********************************************************************
  logic        irq_en;
  logic        rww_busy;
  logic        reen;
  logic        lock;
  logic        pg_write;
  logic        pg_erase;
  logic        sp_en;
  logic [2:0]  win;
  fspa_state_t state;
  fspa_state_t next_state;
  logic        ctrl_hit;
  logic        take;
  logic        take_fill;
  logic        take_erase;
  logic        take_write;
  logic        take_lock;
  logic        take_reen;
  logic        op_done;
  logic [7:0]  ctrl_val;

  assign ctrl_hit   = io_addr == `FSPA_CTRL_IO_ADDR;
  assign take       = spm_req && sp_en && win != 3'h0 && state == FSPA_IDLE;
  // One command per store; priority resolves illegal mixes
  assign take_reen  = take && reen;
  assign take_lock  = take && !reen && lock;
  assign take_erase = take && !reen && !lock && pg_erase;
  assign take_write = take && !reen && !lock && !pg_erase && pg_write;
  assign take_fill  = take && !reen && !lock && !pg_erase && !pg_write;

  assign ctrl_val = {irq_en, rww_busy, 1'b0, reen, lock,
                     pg_write, pg_erase, sp_en};

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_en <= 1'b0;
    end
    else if (io_wr_en && ctrl_hit)
    begin
      irq_en <= io_wdata[`FSPA_BIT_IRQ_EN];
    end
  end

  // Command bits stay set while an erase or write runs, then clear
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {reen, lock, pg_write, pg_erase, sp_en} <= 5'h00;
      win <= 3'h0;
    end
    else if (io_wr_en && ctrl_hit && state == FSPA_IDLE && !take)
    begin
      reen     <= io_wdata[`FSPA_BIT_REENABLE];
      lock     <= io_wdata[`FSPA_BIT_LOCK];
      pg_write <= io_wdata[`FSPA_BIT_PAGE_WRITE];
      pg_erase <= io_wdata[`FSPA_BIT_PAGE_ERASE];
      sp_en    <= io_wdata[`FSPA_BIT_ENABLE];
      win      <= io_wdata[`FSPA_BIT_ENABLE] ? `FSPA_SPM_WINDOW_CYC : 3'h0;
    end
    else if (take_fill || take_lock || take_reen || op_done)
    begin
      {reen, lock, pg_write, pg_erase, sp_en} <= 5'h00;
      win <= 3'h0;
    end
    else if (take)
    begin
      win <= 3'h0;
    end
    else if (state == FSPA_IDLE && win != 3'h0)
    begin
      win <= win - 3'h1;
      if (win == 3'h1)
      begin
        {reen, lock, pg_write, pg_erase, sp_en} <= 5'h00;
      end
    end
  end

  // Busy only for targets in the concurrent region; set and clear exclusive
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rww_busy <= 1'b0;
    end
    else if ((take_erase || take_write) &&
             fspa_in_rww({z_page, 6'h00}))
    begin
      rww_busy <= 1'b1;
    end
    else if (take_reen)
    begin
      rww_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      io_rdata <= `FSPA_CTRL_RESET;
    end
    else
    begin
      io_rdata <= (io_rd_en && ctrl_hit) ? ctrl_val : 8'h00;
    end
  end

  // ********************************************************************
  // Page sequencer
  // ********************************************************************
  logic [6:0]  op_page;
  logic [6:0]  stream_idx;
  logic        rd_pend;
  logic [5:0]  rd_pend_word;
  logic [15:0] buf_rd_data;
  logic [31:0] prog_cnt;
  logic        stream_rd;

  assign stream_rd = state == FSPA_STREAM && stream_idx != `FSPA_PAGE_WORDS;
  assign op_done   = state == FSPA_PROG && prog_cnt == 32'(PROG_CYC - 1);

  always_comb
  begin
    next_state = state;
    case (state)
      FSPA_IDLE:
      begin
        if (take_write)
        begin
          next_state = FSPA_STREAM;
        end
        else if (take_erase)
        begin
          next_state = FSPA_PROG;
        end
      end
      FSPA_STREAM:
      begin
        if (stream_idx == `FSPA_PAGE_WORDS && !rd_pend)
        begin
          next_state = FSPA_PROG;
        end
      end
      FSPA_PROG:
      begin
        if (op_done)
        begin
          next_state = FSPA_IDLE;
        end
      end
      default: next_state = FSPA_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= FSPA_IDLE;
      core_stall <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      core_stall <= next_state != FSPA_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_page    <= 7'h00;
      stream_idx <= 7'h00;
      prog_cnt   <= 32'h0;
    end
    else
    begin
      if (take_write || take_erase)
      begin
        op_page    <= z_page;
        stream_idx <= 7'h00;                 // word bits not used here
      end
      else if (stream_rd)
      begin
        stream_idx <= stream_idx + 7'h01;
      end
      prog_cnt <= (state == FSPA_PROG) ? prog_cnt + 32'h1 : 32'h0;
    end
  end

  fspa_page_buf #(
    .DW    (16),
    .DEPTH (64),
    .AW    (6)
  ) u_page_buf (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .wr_en   (take_fill),
    .wr_addr (z_word),
    .wr_data (spm_data),
    .rd_en   (stream_rd),
    .rd_addr (stream_idx[5:0]),
    .rd_data (buf_rd_data)
  );

  // Read data lags the request by one cycle, so the word index travels along
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_pend      <= 1'b0;
      rd_pend_word <= 6'h00;
      flash_wr     <= '0;
    end
    else
    begin
      rd_pend      <= stream_rd;
      rd_pend_word <= stream_idx[5:0];
      flash_wr.valid <= rd_pend;
      flash_wr.addr  <= {op_page, rd_pend_word};
      flash_wr.data  <= buf_rd_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flash_cmd <= '0;
    end
    else
    begin
      flash_cmd.erase <= take_erase;
      flash_cmd.write <= state == FSPA_STREAM && next_state == FSPA_PROG;
      flash_cmd.lock  <= take_lock;
      if (take_erase || take_write)
      begin
        flash_cmd.page <= z_page;
      end
      if (take_lock)
      begin
        flash_cmd.lock_data <= spm_data[7:0];
      end
    end
  end

  // ********************************************************************
  // Program-memory load and ready request
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lpm_valid     <= 1'b0;
      lpm_addr      <= 13'h0000;
      lpm_byte_hi   <= 1'b0;
      lpm_blocked   <= 1'b0;
      spm_ready_irq <= 1'b0;
    end
    else
    begin
      lpm_valid   <= lpm_req;
      if (lpm_req)
      begin
        lpm_addr    <= z_waddr;
        lpm_byte_hi <= z_ptr[`FSPA_Z_BYTE_BIT];
        lpm_blocked <= rww_busy && fspa_in_rww(z_waddr);
      end
      spm_ready_irq <= irq_en && !sp_en;
    end
  end

  fspa_boot_cfg u_boot_cfg (
    .clk_sys          (clk_sys),
    .reset_n          (reset_n),
    .boot_size_sel_hi (boot_size_sel_hi),
    .boot_size_sel_lo (boot_size_sel_lo),
    .sect_info        (sect_info),
    .cfg_valid        (cfg_valid)
  );

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_rww_block_range: assert property (lpm_valid && lpm_blocked |->
    lpm_addr <= 13'h1BFF)
    else $error("load blocked outside concurrent region");
  chk_blocking_rewrite_region_no_busy: assert property ((take_erase || take_write) &&
    z_page >= 7'h70 && !take_reen |=> rww_busy == $past(rww_busy))
    else $error("blocking region op changed busy flag");
  chk_stream_words: assert property (flash_wr.valid &&
    $past(flash_wr.valid) |-> flash_wr.addr[5:0] ==
    $past(flash_wr.addr[5:0]) + 6'h01)
    else $error("page write words out of order");
  chk_erase_page: assert property (take_erase |=> flash_cmd.erase &&
    flash_cmd.page == $past(z_ptr[13:7]))
    else $error("erase page select wrong");
  chk_write_page: assert property (flash_wr.valid |->
    flash_wr.addr[12:6] == op_page)
    else $error("write page select wrong");
  chk_load_addr: assert property (lpm_req |=>
    lpm_addr == $past(z_ptr[13:1]))
    else $error("load address split wrong");
  chk_load_byte: assert property (lpm_req |=>
    lpm_byte_hi == $past(z_ptr[0]))
    else $error("load byte select wrong");
  chk_ctrl_read: assert property (io_rd_en && ctrl_hit |=>
    io_rdata[5] == 1'b0 && io_rdata[6] == $past(rww_busy) &&
    io_rdata[0] == $past(sp_en))
    else $error("control register read layout wrong");
  chk_write_length: assert property (take_write |-> ##[66:70]
    flash_cmd.write)
    else $error("page write stream length wrong");

  cov_fill: cover property (take_fill);
  cov_erase_rww: cover property (take_erase ##1 rww_busy);
  cov_write_done: cover property (take_write ##[60:80] flash_cmd.write);
  cov_reenable: cover property (rww_busy ##[1:300] take_reen);

endmodule : fspa_flash_self_program_addressing

// ---- hdl/fspa_page_buf.sv ----
// Temporary page buffer with registered read data
`timescale 1ns/10ps
module fspa_page_buf #(
  parameter int unsigned DW    = 16,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = 6
) (
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];

  // No reset on the array; software fills it before any page write
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data <= '0;
    end
    else if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : fspa_page_buf

// ---- verif/fspa_core_model.sv ----
// Processor core model issuing register, store and load requests
`timescale 1ns/10ps
module fspa_core_model
  import fspa_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        core_stall,
  output logic       [5:0] io_addr,
  output logic             io_wr_en,
  output logic             io_rd_en,
  output logic       [7:0] io_wdata,
  output logic             spm_req,
  output logic      [15:0] spm_data,
  output logic             lpm_req,
  output logic      [15:0] z_ptr
);
  // ******************************************************************
  // Request tasks
  // ******************************************************************
  initial
  begin
    {io_addr, io_wr_en, io_rd_en, io_wdata} = '0;
    {spm_req, spm_data, lpm_req, z_ptr} = '0;
  end

  // Released data lines and z_ptr carry the inverse so stale values never match
  task automatic io(input logic wr, input logic [5:0] a,
                    input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_wr_en = wr;
    io_rd_en = !wr;
    @(posedge clk_sys);
    #1;
    io_wr_en = 1'b0;
    io_rd_en = 1'b0;
    io_wdata = ~d;
  endtask : io

  task automatic store_program_memory_instr(input logic [15:0] z, input logic [15:0] d);
    int n;
    @(posedge clk_sys);
    #1;
    for (n = 0; core_stall !== 1'b0 && n < 300; n++)
      @(posedge clk_sys) #1;
    z_ptr    = {z[15:1], 1'b0};
    spm_data = d;
    spm_req  = 1'b1;
    @(posedge clk_sys);
    #1;
    spm_req  = 1'b0;
    z_ptr    = ~z_ptr;
    spm_data = ~d;
  endtask : store_program_memory_instr

  task automatic load_program_memory_instr(input logic [15:0] z);
    @(posedge clk_sys);
    #1;
    z_ptr   = z;
    lpm_req = 1'b1;
    @(posedge clk_sys);
    #1;
    lpm_req = 1'b0;
    z_ptr   = ~z;
  endtask : load_program_memory_instr
endmodule : fspa_core_model

// ---- verif/fspa_flash_self_program_addressing_tb_top.sv ----
// Self-checking bench of the self-program addressing block
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end \
  end
module fspa_flash_self_program_addressing_tb_top
  import fspa_pkg::*;
;
  logic            clk_sys, reset_n, sel_hi, sel_lo;
  logic      [5:0] io_addr;
  logic      [7:0] io_wdata, io_rdata;
  logic            io_wr_en, io_rd_en, spm_req, lpm_req;
  logic     [15:0] spm_data, z_ptr;
  logic            lpm_valid, lpm_byte_hi, lpm_blocked;
  logic            cfg_valid, core_stall, spm_ready_irq;
  logic     [12:0] lpm_addr;
  fspa_flash_cmd_t flash_cmd;
  fspa_flash_wr_t  flash_wr;
  fspa_sect_t      sect_info;
  logic     [15:0] got [64];
  logic      [6:0] exp_pg;
  int              n_mismatch = 0;
  int              n_tests = 0;
  int              n_wr = 0;
  int              n_pw = 0;

  fspa_flash_self_program_addressing #(.PROG_CYC(4)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .boot_size_sel_hi(sel_hi), .boot_size_sel_lo(sel_lo),
    .io_addr(io_addr), .io_wr_en(io_wr_en), .io_rd_en(io_rd_en),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .spm_req(spm_req),
    .spm_data(spm_data), .lpm_req(lpm_req), .z_ptr(z_ptr),
    .lpm_valid(lpm_valid), .lpm_addr(lpm_addr),
    .lpm_byte_hi(lpm_byte_hi), .lpm_blocked(lpm_blocked),
    .flash_cmd(flash_cmd), .flash_wr(flash_wr),
    .sect_info(sect_info), .cfg_valid(cfg_valid),
    .core_stall(core_stall), .spm_ready_irq(spm_ready_irq));

  fspa_core_model core (
    .clk_sys(clk_sys), .core_stall(core_stall), .io_addr(io_addr),
    .io_wr_en(io_wr_en), .io_rd_en(io_rd_en), .io_wdata(io_wdata),
    .spm_req(spm_req), .spm_data(spm_data), .lpm_req(lpm_req),
    .z_ptr(z_ptr));

  // ******************************************************************
  // Clock, monitor and helpers
  // ******************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Mid-cycle sampling, where the registered outputs have settled
  always @(negedge clk_sys)
  begin
    if (flash_wr.valid === 1'b1)
    begin
      `CHK("wr addr", {exp_pg, 6'(n_wr)}, flash_wr.addr)
      got[flash_wr.addr[5:0]] = flash_wr.data;
      n_wr++;
    end
    if (flash_cmd.write === 1'b1)
      n_pw++;
  end

  function automatic fspa_sect_t exp_sect(input logic [1:0] sel);
    fspa_sect_t s;
    s.boot_words = 11'h400 >> sel;
    s.boot_pages = s.boot_words[10:6];
    s.boot_start = 13'(14'h2000 - 14'(s.boot_words));
    s.app_end    = s.boot_start - 13'h1;
    return s;
  endfunction : exp_sect

  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic idle();
    int n;
    for (n = 0; core_stall !== 1'b0 && n < 300; n++)
      @(posedge clk_sys) #1;
  endtask : idle

  task automatic boot(input logic [1:0] sel);
    int n;
    reset_n = 1'b0;
    {sel_hi, sel_lo} = sel;
    repeat (3) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    for (n = 0; cfg_valid !== 1'b1 && n < 20; n++)
      @(posedge clk_sys) #1;
    `CHK("sect", exp_sect(sel), sect_info)
    {sel_hi, sel_lo} = ~sel;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("strap hold", exp_sect(sel), sect_info)
  endtask : boot

  initial
  begin
    logic [15:0] z;
    logic  [6:0] pg;
    logic  [5:0] ws [3];
    logic [15:0] ds [3];
    int          i;
    void'($urandom(56650));
    {reset_n, sel_hi, sel_lo} = '0;
    for (i = 0; i < 4; i++)
      boot(2'(i));
    for (i = 0; i < 16; i++)
    begin
      z = (i == 0) ? 16'hFFFF : 16'($urandom);
      core.load_program_memory_instr(z);
      `CHK("lpm addr", z[13:1], lpm_addr)
      `CHK("lpm byte", z[0], lpm_byte_hi)
      `CHK("lpm valid", 1'b1, lpm_valid)
    end
    core.io(1'b1, 6'h37, 8'hE0);
    core.io(1'b0, 6'h37, 8'h00);
    `CHK("ctrl", 8'h80, io_rdata)
    `CHK("irq", 1'b1, spm_ready_irq)
    core.io(1'b0, 6'h36, 8'h00);
    `CHK("unmapped", 8'h00, io_rdata)
    // Erase in the concurrent region, upper pointer bits set
    pg = 7'($urandom_range(111));
    core.io(1'b1, 6'h37, 8'h83);
    core.store_program_memory_instr({2'b11, pg, 7'h00}, 16'h0000);
    `CHK("erase", 1'b1, flash_cmd.erase)
    `CHK("erase page", pg, flash_cmd.page)
    core.load_program_memory_instr(16'h37FE);
    `CHK("rww blocked", 1'b1, lpm_blocked)
    core.load_program_memory_instr(16'h3800);
    `CHK("blocking_rewrite_region open", 1'b0, lpm_blocked)
    idle();
    core.io(1'b0, 6'h37, 8'h00);
    `CHK("busy", 8'hC0, io_rdata)
    core.io(1'b1, 6'h37, 8'h91);
    core.store_program_memory_instr(16'h0000, 16'h0000);
    core.load_program_memory_instr(16'h0000);
    `CHK("reenable", 1'b0, lpm_blocked)
    core.io(1'b1, 6'h37, 8'h83);
    core.store_program_memory_instr({2'b00, 3'h7, 4'($urandom), 7'h00}, 16'h0000);
    idle();
    core.io(1'b0, 6'h37, 8'h00);
    `CHK("blocking_rewrite_region erase", 8'h80, io_rdata)
    ds[0] = 16'($urandom);
    core.io(1'b1, 6'h37, 8'h89);
    core.store_program_memory_instr(16'h0000, ds[0]);
    `CHK("lock", 1'b1, flash_cmd.lock)
    `CHK("lock data", ds[0][7:0], flash_cmd.lock_data)
    // Fill first, last and one inner word, then write the page
    ws = '{6'h00, 6'h3F, 6'($urandom_range(62, 1))};
    for (i = 0; i < 3; i++)
    begin
      ds[i] = 16'($urandom);
      core.io(1'b1, 6'h37, 8'h81);
      core.store_program_memory_instr({2'b00, pg, ws[i], 1'b0}, ds[i]);
    end
    // Window runs out: the late store must not reach the buffer
    core.io(1'b1, 6'h37, 8'h81);
    repeat (6) @(posedge clk_sys);
    core.store_program_memory_instr({2'b00, pg, 7'h00}, ~ds[0]);
    core.io(1'b0, 6'h37, 8'h00);
    `CHK("window", 8'h80, io_rdata)
    exp_pg = pg;
    core.io(1'b1, 6'h37, 8'h85);
    core.store_program_memory_instr({2'b00, pg, 7'h00}, 16'h0000);
    idle();
    repeat (2) @(posedge clk_sys);
    `CHK("words", 64, n_wr)
    `CHK("writes", 1, n_pw)
    for (i = 0; i < 3; i++)
      `CHK("buf word", ds[i], got[ws[i]])
    summarize();
  end

  initial
  begin
    #20000;
    n_mismatch++;
    summarize();
  end
endmodule : fspa_flash_self_program_addressing_tb_top
